// ### hdl/dcf_pkg.sv
`default_nettype none

package dcf_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int DEPTH_DEFAULT       = 2048;
	localparam int WIDTH_WIDE          = 18;
	localparam int WIDTH_NARROW        = 9;
	localparam int NARROW_DEPTH_FACTOR = 2;

	// ------------------------------------------------------------
	// Flag thresholds
	// ------------------------------------------------------------
	// Extra word held by the output register in fall-through
	localparam int FALL_THROUGH_MODE_EXTRA_WORDS = 1;
	// Half-full trips at D/2 plus this many words
	localparam int STD_HALF_EXTRA   = 1;
	localparam int FALL_THROUGH_MODE_HALF_EXTRA  = 2;
	// Almost-empty is high above n plus this many words
	localparam int STD_AE_EXTRA     = 0;
	localparam int FALL_THROUGH_MODE_AE_EXTRA    = 1;

	// ------------------------------------------------------------
	// Levels and reset values
	// ------------------------------------------------------------
	localparam logic FLAG_ACTIVE    = 1'h0;
	localparam logic FLAG_IDLE      = 1'h1;
	localparam logic PIN_FALL_SEL   = 1'h1;
	localparam logic PIN_NARROW_SEL = 1'h1;
	localparam logic SYNC_RESET_VAL = 1'h0;
	localparam logic MRS_RESET_VAL  = 1'h0;

	// ------------------------------------------------------------
	// Timing modes
	// ------------------------------------------------------------
	typedef enum logic {
		DCF_MODE_STANDARD,
		DCF_MODE_FALL_THROUGH
	} dcf_mode_e;

endpackage

`default_nettype wire

// ### hdl/dcf_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo #(
	parameter int DEPTH       = dcf_pkg::DEPTH_DEFAULT,
	parameter int WIDTH       = dcf_pkg::WIDTH_WIDE,
	parameter int NWIDTH      = dcf_pkg::WIDTH_NARROW,
	localparam int PTR_W      = $clog2(dcf_pkg::NARROW_DEPTH_FACTOR * DEPTH) + 1
) (
	// System clock and reset
	input  wire logic             CLK_SYS,
	input  wire logic             RESET_N,
	// Master reset and straps
	input  wire logic             MASTER_RESET_N,
	input  wire logic             FALL_THROUGH_SELECT_SERIAL_IN,
	input  wire logic             NARROW_BUS_SEL,
	// Flag offsets
	input  wire logic [PTR_W-1:0] EMPTY_OFFSET,
	input  wire logic [PTR_W-1:0] FULL_OFFSET,
	// Write port
	input  wire logic             WRITE_CLK,
	input  wire logic             WRITE_EN_N,
	input  wire logic [WIDTH-1:0] DATA_IN,
	// Read port
	input  wire logic             READ_CLK,
	input  wire logic             READ_EN_N,
	output logic      [WIDTH-1:0] DATA_OUT,
	// Status flags
	output logic                  EMPTY_FLAG_N,
	output logic                  OUTPUT_READY_N,
	output logic                  FULL_FLAG_N,
	output logic                  INPUT_READY_N,
	output logic                  ALMOST_EMPTY_N,
	output logic                  ALMOST_FULL_N,
	output logic                  HALF_FULL_N,
	output logic                  FALL_THROUGH_MODE
);

	// ------------------------------------------------------------
	// Local constants
	// ------------------------------------------------------------
	localparam int AW  = PTR_W - 1;
	localparam int MEM = dcf_pkg::NARROW_DEPTH_FACTOR * DEPTH;
	localparam logic [PTR_W-1:0] CAP_WIDE   = PTR_W'(DEPTH);
	localparam logic [PTR_W-1:0] CAP_NARROW = PTR_W'(MEM);
	localparam logic [WIDTH-1:0] NARROW_MASK = WIDTH'((1 << NWIDTH) - 1);
	localparam logic [WIDTH-1:0] WIDE_MASK   = {WIDTH{1'h1}};
	localparam logic [PTR_W-1:0] PTR_ZERO    = {PTR_W{1'h0}};
	localparam logic [WIDTH-1:0] DATA_ZERO   = {WIDTH{1'h0}};

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [2:0]           wclk_sync_reg;
	logic [2:0]           rclk_sync_reg;
	logic [1:0]           wen_sync_reg;
	logic [1:0]           ren_sync_reg;
	logic [1:0]           mrs_sync_reg;
	logic [1:0]           ft_sync_reg;
	logic [1:0]           nb_sync_reg;
	logic [WIDTH-1:0]     din_s1_reg;
	logic [WIDTH-1:0]     din_s2_reg;
	logic [PTR_W-1:0]     eoff_s1_reg;
	logic [PTR_W-1:0]     eoff_s2_reg;
	logic [PTR_W-1:0]     foff_s1_reg;
	logic [PTR_W-1:0]     foff_s2_reg;
	dcf_pkg::dcf_mode_e   mode_reg;
	logic                 narrow_reg;
	logic [WIDTH-1:0]     mem_reg [MEM];
	logic [PTR_W-1:0]     wr_ptr_reg;
	logic [PTR_W-1:0]     wr_ptr_next;
	logic [PTR_W-1:0]     rd_ptr_ws_reg;
	logic                 ov_ws_reg;
	logic                 full_reg;
	logic                 half_reg;
	logic                 afull_reg;
	logic [PTR_W-1:0]     rd_ptr_reg;
	logic [PTR_W-1:0]     rd_ptr_next;
	logic [PTR_W-1:0]     wr_ptr_rs1_reg;
	logic [PTR_W-1:0]     wr_ptr_rs2_reg;
	logic                 empty_reg;
	logic                 ae_high_reg;
	logic                 ov_reg;
	logic                 ov_next;
	logic [WIDTH-1:0]     dout_reg;
	logic                 w_edge;
	logic                 r_edge;
	logic                 mrs_active;
	logic                 fall_through_mode;
	logic                 wr_take;
	logic                 std_take;
	logic                 pop;
	logic                 load;
	logic                 mem_has;
	logic [PTR_W-1:0]     cap_std;
	logic [PTR_W-1:0]     depth_eff;
	logic [PTR_W-1:0]     half_thr;
	logic [PTR_W-1:0]     afull_thr;
	logic [PTR_W-1:0]     ae_thr;
	logic [PTR_W-1:0]     wtotal;
	logic [PTR_W-1:0]     rtotal;
	logic [WIDTH-1:0]     data_mask;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Port clocks get a third stage so an edge can be detected
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			wclk_sync_reg <= {3{dcf_pkg::SYNC_RESET_VAL}};
			rclk_sync_reg <= {3{dcf_pkg::SYNC_RESET_VAL}};
		end
		else
		begin
			wclk_sync_reg <= {wclk_sync_reg[1:0], WRITE_CLK};
			rclk_sync_reg <= {rclk_sync_reg[1:0], READ_CLK};
		end
	end

	// Enables idle high, master reset held asserted until the pin syncs in
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			wen_sync_reg <= {2{dcf_pkg::FLAG_IDLE}};
			ren_sync_reg <= {2{dcf_pkg::FLAG_IDLE}};
			mrs_sync_reg <= {2{dcf_pkg::MRS_RESET_VAL}};
			ft_sync_reg  <= {2{dcf_pkg::SYNC_RESET_VAL}};
			nb_sync_reg  <= {2{dcf_pkg::SYNC_RESET_VAL}};
		end
		else
		begin
			wen_sync_reg <= {wen_sync_reg[0], WRITE_EN_N};
			ren_sync_reg <= {ren_sync_reg[0], READ_EN_N};
			mrs_sync_reg <= {mrs_sync_reg[0], MASTER_RESET_N};
			ft_sync_reg  <= {ft_sync_reg[0], FALL_THROUGH_SELECT_SERIAL_IN};
			nb_sync_reg  <= {nb_sync_reg[0], NARROW_BUS_SEL};
		end
	end

	// Data and offsets; offsets are quasi-static, so a plain pair is enough
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			din_s1_reg  <= DATA_ZERO;
			din_s2_reg  <= DATA_ZERO;
			eoff_s1_reg <= PTR_ZERO;
			eoff_s2_reg <= PTR_ZERO;
			foff_s1_reg <= PTR_ZERO;
			foff_s2_reg <= PTR_ZERO;
		end
		else
		begin
			din_s1_reg  <= DATA_IN;
			din_s2_reg  <= din_s1_reg;
			eoff_s1_reg <= EMPTY_OFFSET;
			eoff_s2_reg <= eoff_s1_reg;
			foff_s1_reg <= FULL_OFFSET;
			foff_s2_reg <= foff_s1_reg;
		end
	end

	// Edge events; data must hold one system period past the port edge
	assign w_edge     = wclk_sync_reg[1] & ~wclk_sync_reg[2];
	assign r_edge     = rclk_sync_reg[1] & ~rclk_sync_reg[2];
	assign mrs_active = ~mrs_sync_reg[1];

	// ------------------------------------------------------------
	// Mode latch
	// ------------------------------------------------------------
	// Straps follow the pins for as long as master reset is held
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			mode_reg   <= dcf_pkg::DCF_MODE_STANDARD;
			narrow_reg <= 1'h0;
		end
		else if (mrs_active)
		begin
			mode_reg   <= (ft_sync_reg[1] == dcf_pkg::PIN_FALL_SEL) ?
				dcf_pkg::DCF_MODE_FALL_THROUGH : dcf_pkg::DCF_MODE_STANDARD;
			narrow_reg <= (nb_sync_reg[1] == dcf_pkg::PIN_NARROW_SEL);
		end
	end

	// Depth and thresholds for the latched configuration
	always_comb
	begin
		fall_through_mode      = (mode_reg == dcf_pkg::DCF_MODE_FALL_THROUGH);
		cap_std   = narrow_reg ? CAP_NARROW : CAP_WIDE;
		depth_eff = cap_std + (fall_through_mode ? PTR_W'(dcf_pkg::FALL_THROUGH_MODE_EXTRA_WORDS) : PTR_ZERO);
		half_thr  = (cap_std >> 1) + (fall_through_mode ? PTR_W'(dcf_pkg::FALL_THROUGH_MODE_HALF_EXTRA) :
			PTR_W'(dcf_pkg::STD_HALF_EXTRA));
		afull_thr = depth_eff - foff_s2_reg;
		ae_thr    = eoff_s2_reg + (fall_through_mode ? PTR_W'(dcf_pkg::FALL_THROUGH_MODE_AE_EXTRA) :
			PTR_W'(dcf_pkg::STD_AE_EXTRA));
		data_mask = narrow_reg ? NARROW_MASK : WIDE_MASK;
	end

	// ------------------------------------------------------------
	// Write side
	// ------------------------------------------------------------
	// Word count as the write side sees it, output register included
	always_comb
	begin
		wr_take     = w_edge & ~wen_sync_reg[1] & ~full_reg;
		wr_ptr_next = wr_ptr_reg + PTR_W'(wr_take);
		wtotal      = wr_ptr_next - rd_ptr_ws_reg + PTR_W'(ov_ws_reg & fall_through_mode);
	end

	// Write pointer
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
			wr_ptr_reg <= PTR_ZERO;
		else if (mrs_active)
			wr_ptr_reg <= PTR_ZERO;
		else
			wr_ptr_reg <= wr_ptr_next;
	end

	// Storage; no reset, contents are don't-care until written
	always_ff @(posedge CLK_SYS)
	begin
		if (wr_take)
			mem_reg[wr_ptr_reg[AW-1:0]] <= din_s2_reg & data_mask;
	end

	// Read pointer copy is stage one, full register stage two
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rd_ptr_ws_reg <= PTR_ZERO;
			ov_ws_reg     <= 1'h0;
			full_reg      <= 1'h0;
			half_reg      <= 1'h0;
			afull_reg     <= 1'h0;
		end
		else if (mrs_active)
		begin
			rd_ptr_ws_reg <= PTR_ZERO;
			ov_ws_reg     <= 1'h0;
			full_reg      <= 1'h0;
			half_reg      <= 1'h0;
			afull_reg     <= 1'h0;
		end
		else if (w_edge)
		begin
			rd_ptr_ws_reg <= rd_ptr_reg;
			ov_ws_reg     <= ov_reg;
			full_reg      <= (wtotal == depth_eff);
			half_reg      <= (wtotal >= half_thr);
			afull_reg     <= (wtotal >= afull_thr);
		end
	end

	// ------------------------------------------------------------
	// Read side
	// ------------------------------------------------------------
	// Standard reads on request; fall-through loads its output register
	always_comb
	begin
		std_take    = r_edge & ~fall_through_mode & ~ren_sync_reg[1] & ~empty_reg;
		pop         = r_edge & fall_through_mode & ov_reg & ~ren_sync_reg[1];
		mem_has     = (wr_ptr_rs2_reg != rd_ptr_reg);
		load        = r_edge & fall_through_mode & mem_has & (~ov_reg | pop);
		rd_ptr_next = rd_ptr_reg + PTR_W'(std_take | load);
		ov_next     = load | (ov_reg & ~pop);
		rtotal      = wr_ptr_rs1_reg - rd_ptr_next + PTR_W'(ov_next);
	end

	// Write pointer passes two stages on read edges
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			wr_ptr_rs1_reg <= PTR_ZERO;
			wr_ptr_rs2_reg <= PTR_ZERO;
		end
		else if (mrs_active)
		begin
			wr_ptr_rs1_reg <= PTR_ZERO;
			wr_ptr_rs2_reg <= PTR_ZERO;
		end
		else if (r_edge)
		begin
			wr_ptr_rs1_reg <= wr_ptr_reg;
			wr_ptr_rs2_reg <= wr_ptr_rs1_reg;
		end
	end

	// Read pointer and output-register occupancy
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rd_ptr_reg <= PTR_ZERO;
			ov_reg     <= 1'h0;
		end
		else if (mrs_active)
		begin
			rd_ptr_reg <= PTR_ZERO;
			ov_reg     <= 1'h0;
		end
		else
		begin
			rd_ptr_reg <= rd_ptr_next;
			ov_reg     <= ov_next;
		end
	end

	// Read-side flags, updated on read edges only
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			empty_reg   <= 1'h1;
			ae_high_reg <= 1'h0;
		end
		else if (mrs_active)
		begin
			empty_reg   <= 1'h1;
			ae_high_reg <= 1'h0;
		end
		else if (r_edge)
		begin
			empty_reg   <= (wr_ptr_rs1_reg == rd_ptr_next);
			ae_high_reg <= (rtotal > ae_thr);
		end
	end

	// Output data register
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
			dout_reg <= DATA_ZERO;
		else if (mrs_active)
			dout_reg <= DATA_ZERO;
		else if (std_take | load)
			dout_reg <= mem_reg[rd_ptr_reg[AW-1:0]];
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Flags of the unused mode idle high so they never look asserted
	assign DATA_OUT          = dout_reg;
	assign EMPTY_FLAG_N      = fall_through_mode ? dcf_pkg::FLAG_IDLE : ~empty_reg;
	assign OUTPUT_READY_N    = fall_through_mode ? ~ov_reg : dcf_pkg::FLAG_IDLE;
	assign FULL_FLAG_N       = fall_through_mode ? dcf_pkg::FLAG_IDLE : ~full_reg;
	assign INPUT_READY_N     = fall_through_mode ? full_reg : dcf_pkg::FLAG_IDLE;
	assign ALMOST_EMPTY_N    = ae_high_reg;
	assign ALMOST_FULL_N     = ~afull_reg;
	assign HALF_FULL_N       = ~half_reg;
	assign FALL_THROUGH_MODE = fall_through_mode;

endmodule

`default_nettype wire

// ### bench/dcf_fifo_sva.sv
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo_sva #(
	parameter int WIDTH = 18
) (
	// Clock and resets
	input wire logic             CLK_SYS,
	input wire logic             RESET_N,
	input wire logic             MASTER_RESET_N,
	// Sampled port clocks
	input wire logic             WRITE_CLK,
	input wire logic             READ_CLK,
	// Data and flags
	input wire logic [WIDTH-1:0] DATA_OUT,
	input wire logic             EMPTY_FLAG_N,
	input wire logic             OUTPUT_READY_N,
	input wire logic             FULL_FLAG_N,
	input wire logic             INPUT_READY_N,
	input wire logic             ALMOST_EMPTY_N,
	input wire logic             ALMOST_FULL_N,
	input wire logic             HALF_FULL_N,
	input wire logic             FALL_THROUGH_MODE
);
	// ----------------------------------------
	// Settle window after master reset
	// ----------------------------------------
	// Synced release lags the pin, so wait a few cycles before judging
	logic [2:0] mrs_cnt_reg;
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
			mrs_cnt_reg <= 3'h0;
		else if (!MASTER_RESET_N)
			mrs_cnt_reg <= 3'h0;
		else if (mrs_cnt_reg != 3'h7)
			mrs_cnt_reg <= mrs_cnt_reg + 3'h1;
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (mrs_cnt_reg != 3'h7);

	// Mode selects which flag pair is live
	chk_std_idle: assert property (!FALL_THROUGH_MODE |-> OUTPUT_READY_N && INPUT_READY_N)
		else $error("fall-through flags active in standard mode");
	chk_fall_idle: assert property (FALL_THROUGH_MODE |-> EMPTY_FLAG_N && FULL_FLAG_N)
		else $error("standard flags active in fall-through mode");
	// Full and empty imply the threshold flags already tripped
	chk_full_thresh: assert property (!FULL_FLAG_N |-> !ALMOST_FULL_N && !HALF_FULL_N)
		else $error("full without almost-full and half-full");
	chk_ir_thresh: assert property (FALL_THROUGH_MODE && INPUT_READY_N |-> !ALMOST_FULL_N)
		else $error("input-ready high without almost-full");
	chk_empty_ae: assert property (!FALL_THROUGH_MODE && !EMPTY_FLAG_N |-> !ALMOST_EMPTY_N)
		else $error("empty without almost-empty");
	// Flags move only after their own port clock
	chk_wr_domain: assert property (($changed(FULL_FLAG_N) || $changed(INPUT_READY_N)
		|| $changed(ALMOST_FULL_N) || $changed(HALF_FULL_N))
		|-> ($past(WRITE_CLK, 1) || $past(WRITE_CLK, 2) || $past(WRITE_CLK, 3)))
		else $error("write-side flag moved without write clock");
	chk_rd_domain: assert property (($changed(EMPTY_FLAG_N) || $changed(OUTPUT_READY_N)
		|| $changed(ALMOST_EMPTY_N))
		|-> ($past(READ_CLK, 1) || $past(READ_CLK, 2) || $past(READ_CLK, 3)))
		else $error("read-side flag moved without read clock");
	// Registered flags never glitch between port events
	chk_ef_steady: assert property ($changed(EMPTY_FLAG_N) |=> $stable(EMPTY_FLAG_N)[*4])
		else $error("empty flag glitched");
	chk_full_steady: assert property (($changed(FULL_FLAG_N) || $changed(INPUT_READY_N))
		|=> ($stable(FULL_FLAG_N) && $stable(INPUT_READY_N))[*4])
		else $error("full or input-ready glitched");
	// No data movement while nothing is held
	chk_empty_hold: assert property (!FALL_THROUGH_MODE && !EMPTY_FLAG_N ##1 !EMPTY_FLAG_N
		|=> $stable(DATA_OUT))
		else $error("data changed while empty");
	// Same-cycle check: the first load lands on the edge that lowers output-ready
	chk_or_hold: assert property (FALL_THROUGH_MODE && OUTPUT_READY_N ##1 OUTPUT_READY_N
		|-> $stable(DATA_OUT))
		else $error("data changed while output not ready");
endmodule

bind dcf_fifo dcf_fifo_sva #(.WIDTH(WIDTH)) dcf_fifo_sva_i (
	.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .MASTER_RESET_N(MASTER_RESET_N),
	.WRITE_CLK(WRITE_CLK), .READ_CLK(READ_CLK), .DATA_OUT(DATA_OUT),
	.EMPTY_FLAG_N(EMPTY_FLAG_N), .OUTPUT_READY_N(OUTPUT_READY_N), .FULL_FLAG_N(FULL_FLAG_N),
	.INPUT_READY_N(INPUT_READY_N), .ALMOST_EMPTY_N(ALMOST_EMPTY_N),
	.ALMOST_FULL_N(ALMOST_FULL_N), .HALF_FULL_N(HALF_FULL_N),
	.FALL_THROUGH_MODE(FALL_THROUGH_MODE));

`default_nettype wire

// ### bench/dcf_port_model.sv
`timescale 1ns/1ps
`default_nettype none

module dcf_port_model #(
	parameter int WIDTH = 18
) (
	// Sampling clock
	input  wire logic             clk,
	// Writer side
	output logic                  write_clk,
	output logic                  write_en_n,
	output logic      [WIDTH-1:0] data_in,
	// Reader side
	output logic                  read_clk,
	output logic                  read_en_n
);
	// Idle: clocks low, enables off
	initial
	begin
		write_clk = 1'h0;
		read_clk = 1'h0;
		write_en_n = 1'h1;
		read_en_n = 1'h1;
		data_in = '0;
	end

	// One port clock pulse; enable and data held well around the edge
	task automatic port_edge(input logic rd, input logic en_n, input logic [WIDTH-1:0] d);
		@(posedge clk);
		if (rd)
			read_en_n <= en_n;
		else
		begin
			write_en_n <= en_n;
			data_in <= d;
		end
		repeat (2) @(posedge clk);
		if (rd)
			read_clk <= 1'h1;
		else
			write_clk <= 1'h1;
		repeat (4) @(posedge clk);
		if (rd)
			read_clk <= 1'h0;
		else
			write_clk <= 1'h0;
		repeat (3) @(posedge clk);
		// Released data flips so a late capture shows up as bad data
		read_en_n <= 1'h1;
		write_en_n <= 1'h1;
		data_in <= ~d;
	endtask
endmodule

`default_nettype wire

// ### bench/dcf_fifo_test.sv
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo_test;
	localparam int DEPTH = 8;
	localparam int PTR_W = $clog2(2 * DEPTH) + 1;

	// ----------------------------------------
	// Stimulus and observation
	// ----------------------------------------
	logic             CLK_SYS = 1'h0;
	logic             RESET_N = 1'h0;
	logic             MASTER_RESET_N = 1'h1;
	logic             FALL_THROUGH_SELECT_SERIAL_IN = 1'h0;
	logic             NARROW_BUS_SEL = 1'h0;
	logic [PTR_W-1:0] EMPTY_OFFSET = '0;
	logic [PTR_W-1:0] FULL_OFFSET = '0;
	wire logic        WRITE_CLK, WRITE_EN_N, READ_CLK, READ_EN_N;
	wire logic [17:0] DATA_IN, DATA_OUT;
	wire logic        EMPTY_FLAG_N, OUTPUT_READY_N, FULL_FLAG_N, INPUT_READY_N;
	wire logic        ALMOST_EMPTY_N, ALMOST_FULL_N, HALF_FULL_N, FALL_THROUGH_MODE;
	int               n_fail = 0;
	int               checks_done = 0;
	int               seed = 11;
	int               fw, d_eff, cap, n, m;
	logic [17:0]      q[$];

	// 100 MHz system clock
	always #5 CLK_SYS = ~CLK_SYS;

	dcf_fifo #(.DEPTH(DEPTH)) dcf_fifo_i (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
		.MASTER_RESET_N(MASTER_RESET_N), .FALL_THROUGH_SELECT_SERIAL_IN(FALL_THROUGH_SELECT_SERIAL_IN),
		.NARROW_BUS_SEL(NARROW_BUS_SEL), .EMPTY_OFFSET(EMPTY_OFFSET), .FULL_OFFSET(FULL_OFFSET),
		.WRITE_CLK(WRITE_CLK), .WRITE_EN_N(WRITE_EN_N), .DATA_IN(DATA_IN), .READ_CLK(READ_CLK),
		.READ_EN_N(READ_EN_N), .DATA_OUT(DATA_OUT), .EMPTY_FLAG_N(EMPTY_FLAG_N),
		.OUTPUT_READY_N(OUTPUT_READY_N), .FULL_FLAG_N(FULL_FLAG_N), .INPUT_READY_N(INPUT_READY_N),
		.ALMOST_EMPTY_N(ALMOST_EMPTY_N), .ALMOST_FULL_N(ALMOST_FULL_N), .HALF_FULL_N(HALF_FULL_N),
		.FALL_THROUGH_MODE(FALL_THROUGH_MODE));
	dcf_port_model #(.WIDTH(18)) dcf_port_model_i (.clk(CLK_SYS), .write_clk(WRITE_CLK),
		.write_en_n(WRITE_EN_N), .data_in(DATA_IN), .read_clk(READ_CLK), .read_en_n(READ_EN_N));

	// ----------------------------------------
	// Compare, model and report
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("Checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Write-side flags against words held
	task automatic chk_wside();
		check(HALF_FULL_N, q.size() < d_eff / 2 + 1 + fw);
		check(ALMOST_FULL_N, q.size() < cap - m);
		check(fw ? INPUT_READY_N : !FULL_FLAG_N, q.size() == cap);
	endtask

	// Read-side flags; fall-through shows the head word unasked
	task automatic chk_rside();
		check(ALMOST_EMPTY_N, q.size() > n + fw);
		check(fw ? OUTPUT_READY_N : !EMPTY_FLAG_N, q.size() == 0);
		if (fw != 0 && q.size() > 0)
			check(DATA_OUT, q[0]);
	endtask

	// Strap, fill past capacity, then drain past empty
	task automatic run(input logic fwm, input logic nar);
		logic [17:0] d;
		fw = fwm;
		d_eff = nar ? 2 * DEPTH : DEPTH;
		cap = d_eff + fw;
		n = 1 + (($random(seed) & 32'h7FFFFFFF) % (d_eff - 2));
		m = 1 + (($random(seed) & 32'h7FFFFFFF) % (d_eff - 2));
		q.delete();
		d = '0;
		@(posedge CLK_SYS);
		MASTER_RESET_N <= 1'h0;
		FALL_THROUGH_SELECT_SERIAL_IN <= fwm;
		NARROW_BUS_SEL <= nar;
		EMPTY_OFFSET <= n[PTR_W-1:0];
		FULL_OFFSET <= m[PTR_W-1:0];
		repeat (6) @(posedge CLK_SYS);
		MASTER_RESET_N <= 1'h1;
		repeat (5) @(posedge CLK_SYS);
		check(FALL_THROUGH_MODE, fwm);
		chk_wside();
		chk_rside();
		for (int i = 0; i <= cap; i++)
		begin
			d = 18'($random(seed));
			dcf_port_model_i.port_edge(1'h0, 1'h1, ~d);
			dcf_port_model_i.port_edge(1'h0, 1'h0, d);
			if (q.size() < cap)
				q.push_back(nar ? (d & 18'h001FF) : d);
			chk_wside();
			if (i == 0)
			begin
				repeat (1 + fw) dcf_port_model_i.port_edge(1'h1, 1'h1, '0);
				check(fw ? OUTPUT_READY_N : EMPTY_FLAG_N, fw);
			end
			repeat (3) dcf_port_model_i.port_edge(1'h1, 1'h1, '0);
			chk_rside();
		end
		for (int i = 0; i <= cap; i++)
		begin
			dcf_port_model_i.port_edge(1'h1, 1'h0, '0);
			if (q.size() > 0)
				d = q.pop_front();
			if (fw == 0)
				check(DATA_OUT, d);
			dcf_port_model_i.port_edge(1'h1, 1'h1, '0);
			repeat (3) dcf_port_model_i.port_edge(1'h0, 1'h1, '0);
			chk_wside();
			chk_rside();
		end
		$display("Test fall=%0d narrow=%0d n=%0d m=%0d done", fwm, nar, n, m);
	endtask

	// Main sequence: reset values, then every mode and width
	initial
	begin
		repeat (5) @(posedge CLK_SYS);
		RESET_N <= 1'h1;
		repeat (2) @(posedge CLK_SYS);
		check({EMPTY_FLAG_N, FULL_FLAG_N, OUTPUT_READY_N, INPUT_READY_N, ALMOST_EMPTY_N,
			ALMOST_FULL_N, HALF_FULL_N, FALL_THROUGH_MODE}, 8'h76);
		for (int k = 0; k < 4; k++)
			run(k[0], k[1]);
		summarize();
	end

	// Hang guard
	initial
	begin
		repeat (60000) @(posedge CLK_SYS);
		n_fail++;
		$display("Timeout at %0t", $time);
		summarize();
	end
endmodule

`default_nettype wire
